// *** hw/isb_pkg.sv ***
// Shared constants, register map and carrier types of the expansion bus slave.
// Assumes a single core clock; all pin-side signals are sampled by that clock.
package isb_pkg;

    // Register byte offsets on the register bus
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_IOBASE = 8'h04;
    localparam logic [7:0] OFS_MEMBASE = 8'h08;
    localparam logic [7:0] OFS_ROMBASE = 8'h0C;
    localparam logic [7:0] OFS_RDDATA = 8'h10;
    localparam logic [7:0] OFS_WRDATA = 8'h14;
    localparam logic [7:0] OFS_WRADDR = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;
    localparam logic [7:0] OFS_MASK = 8'h20;
    localparam logic [7:0] OFS_PINSTAT = 8'h24;

    // Control register fields
    localparam int CTRL_IOMODE = 0;
    localparam int CTRL_IRQENC = 1;
    localparam int CTRL_CHRDYALT = 2;
    localparam int CTRL_WAIT_LSB = 4;
    localparam int CTRL_IRQSEL_LSB = 8;
    localparam logic [10:0] CTRL_RST = 11'h020;

    // Address decode positions
    localparam int IO_WIN_LSB = 4;
    localparam int MEM_WIN_LSB = 14;
    localparam int REGION_LSB = 17;
    localparam int ROM_WIN_LSB = 14;

    // Reset values of base registers
    localparam logic [11:0] IOBASE_RST = 12'h030;
    localparam logic [9:0] MEMBASE_RST = 10'h000;
    localparam logic [5:0] ROMBASE_RST = 6'h00;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_HOLD = 3'b100
    } isb_state_t;

    // One bit per kind of host access; also the status and mask layout
    typedef struct packed {
        logic romRd;
        logic memRd;
        logic memWr;
        logic portRd;
        logic portWr;
    } isb_evt_t;

    // Pin inputs as seen after the synchroniser
    typedef struct packed {
        logic [19:0] addr;
        logic [6:0] upper;
        logic ale;
        logic sbheN;
        logic memWrN;
        logic memRdN;
        logic lowMemWrN;
        logic lowMemRdN;
        logic portWrN;
        logic portRdN;
        logic dma;
        logic width;
        logic busClk;
        logic busRst;
        logic [15:0] data;
    } isb_pins_t;

    // Idle level of every pin: strobes and high enable high, all else low
    localparam isb_pins_t PINS_IDLE = 55'h7F00000;

endpackage

// *** hw/isb_sync.sv ***
// Two flip-flop synchroniser for a bundle of pin inputs.
// Assumes the inputs are asynchronous to core_clk and change slowly against it.
`timescale 1ns/10ps
module isb_sync #(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1_ff;
    logic [WIDTH-1:0] stage2_ff;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            stage1_ff <= RST_VAL;
            stage2_ff <= RST_VAL;
        end else begin
            stage1_ff <= asyncIn;
            stage2_ff <= stage1_ff;
        end
    end

    assign syncOut = stage2_ff;
endmodule

// *** hw/isb_irq_drive.sv ***
// Drives the four interrupt request pins from one interrupt level.
// Assumes sel and encoded come from configuration on the same clock.
`timescale 1ns/10ps
module isb_irq_drive (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic irqLevel,
    input wire logic encoded,
    input wire logic [2:0] sel,
    output logic [3:0] irqOutputs
);
    logic [3:0] irqOut_ff;
    logic [3:0] nxt_irqOut;

    // Direct lines or 3-bit code plus strobe
    always_comb begin
        nxt_irqOut = 4'h0;
        if (encoded) begin
            nxt_irqOut = {irqLevel, sel};
        end else begin
            nxt_irqOut[sel[1:0]] = irqLevel;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            irqOut_ff <= 4'h0;
        end else begin
            irqOut_ff <= nxt_irqOut;
        end
    end

    assign irqOutputs = irqOut_ff;
endmodule

// *** hw/isb_bus_if.sv ***
// Slave side of the 16/8-bit expansion bus with an APB register port.
// Assumes every bus pin is asynchronous to core_clk; open-collector pins are
// resolved outside from the output enables.
// Contract
// - Capture low 20 address bits at latch fall
// - Sample seven upper bits at latch fall
// - Drive data bus only for own reads
// - High byte enable steers upper lane
// - Wide memory ack inside 128K region
// - Wide port ack on 16-bit port answer
// - Full memory strobes drive memory map in 16-bit
// - Low strobes in 8-bit, full in 16-bit
// - Boot ROM uses low strobes always
// - Port read and write strobes answered
// - Bus reset idles bus side, clears status, keeps config
// - Hold channel ready low for waits
// - Interrupt pins direct or coded plus strobe
// - Width input high selects 16-bit mode
// - Bus clock used only when configured
`timescale 1ns/10ps
module isb_bus_if (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [19:0] latchedAddr,
    input wire logic [6:0] unlatchedUpperAddr,
    input wire logic addrLatchStrobe,
    input wire logic highByteEnableN,
    input wire logic memWriteStrobeN,
    input wire logic memReadStrobeN,
    input wire logic lowMemWriteStrobeN,
    input wire logic lowMemReadStrobeN,
    input wire logic portWriteStrobeN,
    input wire logic portReadStrobeN,
    input wire logic dmaActive,
    input wire logic widthSelect,
    input wire logic hostBusClock,
    input wire logic hostBusReset,
    input wire logic [15:0] sysDataBusIn,
    output logic [15:0] sysDataBusOut,
    output logic [1:0] sysDataBusOe,
    output logic wideMemAckOut,
    output logic wideMemAckOe,
    output logic widePortAckOut,
    output logic widePortAckOe,
    output logic channelReadyOut,
    output logic channelReadyOe,
    output logic [3:0] irqOutputs,
    output logic irq
);
    isb_pkg::isb_pins_t rawPins;
    isb_pkg::isb_pins_t sp;
    isb_pkg::isb_state_t stateFf;
    isb_pkg::isb_state_t nxt_state;
    isb_pkg::isb_evt_t kindFf;
    isb_pkg::isb_evt_t nxt_kind;
    isb_pkg::isb_evt_t statusFf;
    isb_pkg::isb_evt_t maskFf;
    isb_pkg::isb_evt_t evtSet;
    logic [10:0] ctrlFf;
    logic [11:0] ioBaseFf;
    logic [9:0] memBaseFf;
    logic [5:0] romBaseFf;
    logic [15:0] rdDataFf;
    logic [15:0] wrDataFf;
    logic [19:0] addrLFf;
    logic [6:0] upperLFf;
    logic aleDlyFf;
    logic busClkDlyFf;
    logic [3:0] waitCntFf;
    logic [15:0] dataOutFf;
    logic [1:0] laneFf;
    logic [31:0] prdataFf;
    logic pslverrFf;
    logic aleFall;
    logic busClkRise;
    logic waitTick;
    logic ioMode;
    logic wideMode;
    logic ioHit;
    logic memHit;
    logic romHit;
    logic regionHit;
    logic strobeHeld;
    logic apbWr;
    logic apbRd;
    logic [31:0] rdMux;
    logic rdMuxErr;

    // Lane mapping of a host write into a 16-bit word
    function automatic logic [15:0] laneIn(input logic [15:0] bus, input logic wide,
                                           input logic a0, input logic sbheN);
        laneIn = bus;
        if (!wide && a0) begin
            laneIn = {bus[7:0], 8'h00};
        end else if (wide && a0 && !sbheN) begin
            laneIn = {bus[15:8], 8'h00};
        end
    endfunction

    // Lane enables of a host read: low lane only in 8-bit mode; in 16-bit, low lane for even bytes, high lane on enable
    function automatic logic [1:0] laneEn(input logic wide, input logic a0, input logic sbheN);
        if (!wide) begin
            laneEn = 2'b01;
        end else begin
            laneEn = {!sbheN, !a0};
        end
    endfunction

    assign rawPins = '{addr: latchedAddr, upper: unlatchedUpperAddr, ale: addrLatchStrobe,
                       sbheN: highByteEnableN, memWrN: memWriteStrobeN,
                       memRdN: memReadStrobeN, lowMemWrN: lowMemWriteStrobeN,
                       lowMemRdN: lowMemReadStrobeN, portWrN: portWriteStrobeN,
                       portRdN: portReadStrobeN, dma: dmaActive, width: widthSelect,
                       busClk: hostBusClock, busRst: hostBusReset, data: sysDataBusIn};

    isb_sync #(
        .WIDTH($bits(isb_pkg::isb_pins_t)),
        .RST_VAL(isb_pkg::PINS_IDLE)
    ) u_sync (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .asyncIn(rawPins),
        .syncOut(sp)
    );

    assign ioMode = ctrlFf[isb_pkg::CTRL_IOMODE];
    assign wideMode = sp.width;
    assign aleFall = aleDlyFf && !sp.ale;
    assign busClkRise = sp.busClk && !busClkDlyFf;
    // Bus clock paces waits only when configured
    assign waitTick = ctrlFf[isb_pkg::CTRL_CHRDYALT] ? busClkRise : 1'b1;

    // Address decode
    assign regionHit = upperLFf == memBaseFf[6:0];
    assign ioHit = ioMode && addrLFf[15:isb_pkg::IO_WIN_LSB] == ioBaseFf[11:isb_pkg::IO_WIN_LSB];
    assign memHit = !ioMode && regionHit &&
                    addrLFf[16:isb_pkg::MEM_WIN_LSB] == memBaseFf[9:7];
    assign romHit = addrLFf[19:isb_pkg::ROM_WIN_LSB] == romBaseFf;

    // Qualified access request of each kind
    always_comb begin
        nxt_kind = '0;
        if (!sp.dma) begin
            nxt_kind.portWr = ioHit && !sp.portWrN;
            nxt_kind.portRd = ioHit && !sp.portRdN;
            // Full strobes in 16-bit mode, low strobes in 8-bit mode
            nxt_kind.memWr = memHit && (wideMode ? !sp.memWrN : !sp.lowMemWrN);
            nxt_kind.memRd = memHit && (wideMode ? !sp.memRdN : !sp.lowMemRdN);
            nxt_kind.romRd = romHit && !memHit && !sp.lowMemRdN;
        end
    end

    always_comb begin
        unique case (1'b1)
            kindFf.portWr: strobeHeld = !sp.portWrN;
            kindFf.portRd: strobeHeld = !sp.portRdN;
            kindFf.memWr: strobeHeld = wideMode ? !sp.memWrN : !sp.lowMemWrN;
            kindFf.memRd: strobeHeld = wideMode ? !sp.memRdN : !sp.lowMemRdN;
            kindFf.romRd: strobeHeld = !sp.lowMemRdN;
            default: strobeHeld = 1'b0;
        endcase
    end

    // Access sequencer
    always_comb begin
        nxt_state = stateFf;
        unique case (stateFf)
            isb_pkg::ST_IDLE: begin
                if (|nxt_kind) begin
                    nxt_state = (ctrlFf[7:4] != 4'h0) ? isb_pkg::ST_WAIT : isb_pkg::ST_HOLD;
                end
            end
            isb_pkg::ST_WAIT: begin
                if (waitTick && waitCntFf == 4'h1) begin
                    nxt_state = isb_pkg::ST_HOLD;
                end
            end
            isb_pkg::ST_HOLD: begin
                if (!strobeHeld) begin
                    nxt_state = isb_pkg::ST_IDLE;
                end
            end
            default: nxt_state = isb_pkg::ST_IDLE;
        endcase
    end

    // Host bus reset acts as a synchronous reset of the bus side
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            stateFf <= isb_pkg::ST_IDLE;
            kindFf <= '0;
            waitCntFf <= 4'h0;
        end else if (sp.busRst) begin
            stateFf <= isb_pkg::ST_IDLE;
            kindFf <= '0;
            waitCntFf <= 4'h0;
        end else begin
            stateFf <= nxt_state;
            if (stateFf == isb_pkg::ST_IDLE && |nxt_kind) begin
                kindFf <= nxt_kind;
                waitCntFf <= ctrlFf[7:4];
            end else if (stateFf == isb_pkg::ST_WAIT && waitTick) begin
                waitCntFf <= waitCntFf - 4'h1;
            end
        end
    end

    // Address capture at the falling edge of the latch strobe
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            aleDlyFf <= 1'b0;
            busClkDlyFf <= 1'b0;
            addrLFf <= 20'h00000;
            upperLFf <= 7'h00;
        end else begin
            aleDlyFf <= sp.ale;
            busClkDlyFf <= sp.busClk;
            if (aleFall) begin
                addrLFf <= sp.addr;
                upperLFf <= sp.upper;
            end
        end
    end

    // Read data and lane choice, loaded as the access is taken
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            dataOutFf <= 16'h0000;
            laneFf <= 2'b00;
        end else if (stateFf == isb_pkg::ST_IDLE && |nxt_kind) begin
            laneFf <= laneEn(wideMode, addrLFf[0], sp.sbheN);
            if (!wideMode && addrLFf[0]) begin
                dataOutFf <= {8'h00, rdDataFf[15:8]};
            end else begin
                dataOutFf <= rdDataFf;
            end
        end
    end

    // Host write data, sampled each cycle of the hold state while the write strobe is held
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wrDataFf <= 16'h0000;
        end else if (stateFf == isb_pkg::ST_HOLD && strobeHeld &&
                     (kindFf.portWr || kindFf.memWr)) begin
            wrDataFf <= laneIn(sp.data, wideMode, addrLFf[0], sp.sbheN);
        end
    end

    assign evtSet = (stateFf == isb_pkg::ST_HOLD && !strobeHeld) ? kindFf : '0;

    // Pin drive: data only on own reads, open-collector pins pulled low only
    assign sysDataBusOut = dataOutFf;
    assign sysDataBusOe = (stateFf == isb_pkg::ST_HOLD && strobeHeld &&
                           (kindFf.portRd || kindFf.memRd || kindFf.romRd)) ? laneFf : 2'b00;
    assign wideMemAckOut = 1'b0;
    assign wideMemAckOe = wideMode && !ioMode && regionHit && !sp.dma;
    assign widePortAckOut = 1'b0;
    assign widePortAckOe = wideMode && ioHit && !sp.dma && !addrLFf[0] && !sp.sbheN &&
                           (!sp.portRdN || !sp.portWrN);
    assign channelReadyOut = 1'b0;
    assign channelReadyOe = stateFf == isb_pkg::ST_WAIT;

    // Register bus
    assign apbWr = psel && penable && pwrite;
    assign apbRd = psel && penable && !pwrite;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrlFf <= isb_pkg::CTRL_RST;
            ioBaseFf <= isb_pkg::IOBASE_RST;
            memBaseFf <= isb_pkg::MEMBASE_RST;
            romBaseFf <= isb_pkg::ROMBASE_RST;
            rdDataFf <= 16'h0000;
            maskFf <= '0;
        end else if (apbWr) begin
            unique case (paddr)
                isb_pkg::OFS_CTRL: ctrlFf <= pwdata[10:0];
                isb_pkg::OFS_IOBASE: ioBaseFf <= pwdata[11:0];
                isb_pkg::OFS_MEMBASE: memBaseFf <= pwdata[9:0];
                isb_pkg::OFS_ROMBASE: romBaseFf <= pwdata[5:0];
                isb_pkg::OFS_RDDATA: rdDataFf <= pwdata[15:0];
                isb_pkg::OFS_MASK: maskFf <= pwdata[4:0];
                default: ;
            endcase
        end
    end

    // Sticky status; a read clears it, a new event in that cycle wins
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            statusFf <= '0;
        end else if (sp.busRst) begin
            statusFf <= '0;
        end else if (apbRd && paddr == isb_pkg::OFS_STATUS) begin
            // Clears only the bits reported in this read
            statusFf <= evtSet | (statusFf & ~prdataFf[4:0]);
        end else begin
            statusFf <= statusFf | evtSet;
        end
    end

    always_comb begin
        rdMux = 32'h0000_0000;
        rdMuxErr = 1'b0;
        unique case (paddr)
            isb_pkg::OFS_CTRL: rdMux = {21'h000000, ctrlFf};
            isb_pkg::OFS_IOBASE: rdMux = {20'h00000, ioBaseFf};
            isb_pkg::OFS_MEMBASE: rdMux = {22'h000000, memBaseFf};
            isb_pkg::OFS_ROMBASE: rdMux = {26'h0000000, romBaseFf};
            isb_pkg::OFS_RDDATA: rdMux = {16'h0000, rdDataFf};
            isb_pkg::OFS_WRDATA: rdMux = {16'h0000, wrDataFf};
            isb_pkg::OFS_WRADDR: rdMux = {5'h00, upperLFf, addrLFf};
            isb_pkg::OFS_STATUS: rdMux = {27'h0000000, statusFf};
            isb_pkg::OFS_MASK: rdMux = {27'h0000000, maskFf};
            isb_pkg::OFS_PINSTAT: rdMux = {24'h000000, sp.dma, wideMode, 3'h0, stateFf};
            default: rdMuxErr = 1'b1;
        endcase
    end

    // Read data and error are registered in the setup phase
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            prdataFf <= 32'h0000_0000;
            pslverrFf <= 1'b0;
        end else if (psel && !penable) begin
            prdataFf <= pwrite ? 32'h0000_0000 : rdMux;
            pslverrFf <= rdMuxErr;
        end
    end

    assign prdata = prdataFf;
    assign pslverr = psel && penable && pslverrFf;
    assign pready = 1'b1;
    assign irq = |(statusFf & maskFf);

    isb_irq_drive u_irq (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .irqLevel(irq),
        .encoded(ctrlFf[isb_pkg::CTRL_IRQENC]),
        .sel(ctrlFf[10:8]),
        .irqOutputs(irqOutputs)
    );

    // Checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    chk_addr_capture: assert property (aleFall |=> addrLFf == $past(sp.addr))
        else $error("Low address not captured at latch fall");
    chk_upper_capture: assert property (aleFall |=> upperLFf == $past(sp.upper))
        else $error("Upper address not captured at latch fall");
    chk_data_drive: assert property ((|sysDataBusOe) |-> stateFf == isb_pkg::ST_HOLD &&
        !kindFf.portWr && !kindFf.memWr)
        else $error("Data bus driven outside a read answer");
    chk_narrow_lane: assert property ((|sysDataBusOe && !wideMode) |-> sysDataBusOe == 2'b01)
        else $error("Upper lane driven in 8-bit mode");
    chk_mem_region: assert property ((wideMode && !ioMode && regionHit && !sp.dma) |->
        wideMemAckOe && !wideMemAckOut)
        else $error("Wide memory ack missing inside region");
    chk_port_ack: assert property (widePortAckOe |-> ioMode && wideMode)
        else $error("Wide port ack outside 16-bit port mode");
    chk_mem_strobe: assert property ((stateFf == isb_pkg::ST_IDLE && nxt_kind.memRd) |->
        (wideMode ? !sp.memRdN : !sp.lowMemRdN))
        else $error("Memory read taken on the wrong strobe");
    chk_bus_reset: assert property (sp.busRst |=> stateFf == isb_pkg::ST_IDLE &&
        !channelReadyOe && sysDataBusOe == 2'b00)
        else $error("Bus reset did not idle the interface");
    chk_wait_insert: assert property ((stateFf == isb_pkg::ST_IDLE && |nxt_kind &&
        ctrlFf[7:4] != 4'h0 && !sp.busRst) |=> channelReadyOe [*1] ##0
        stateFf == isb_pkg::ST_WAIT)
        else $error("Wait state not inserted");
    chk_wait_length: assert property ((stateFf == isb_pkg::ST_IDLE && |nxt_kind &&
        ctrlFf[7:4] == 4'h2 && !ctrlFf[isb_pkg::CTRL_CHRDYALT] && !sp.busRst) |=>
        channelReadyOe ##1 channelReadyOe ##1 !channelReadyOe)
        else $error("Wait length differs from configured count");
    chk_dma_ignore: assert property ((stateFf == isb_pkg::ST_IDLE && sp.dma) |=>
        stateFf == isb_pkg::ST_IDLE)
        else $error("Access taken while DMA owns the bus");
    chk_ready_release: assert property (stateFf != isb_pkg::ST_WAIT |-> !channelReadyOe)
        else $error("Channel ready held outside a wait");
endmodule

// *** testbench/isb_host_model.sv ***
// Host bus master model: address phase, strobes, wait sampling and data wire.
// Assumes hcycle is called right after a core_clk edge; pins go to the slave.
`timescale 1ns/10ps
module isb_host_model (
    input wire logic core_clk,
    input wire logic [15:0] dataOut,
    input wire logic [1:0] dataOe,
    input wire logic rdyOe,
    input wire logic memAckOe,
    input wire logic portAckOe,
    output isb_pkg::isb_pins_t pins
);
    isb_pkg::isb_pins_t drv = 55'h7F00000;
    logic hostDrv = 1'b0;
    logic clkEn = 1'b0;
    logic busClk = 1'b0;
    logic [15:0] hostData = 16'h0000;
    logic [15:0] floatPat = 16'h5A5A;
    // Undriven lanes show a pattern that changes each cycle
    always_ff @(posedge core_clk) begin
        floatPat <= ~floatPat;
    end
    always_comb begin
        pins = drv;
        pins.busClk = busClk;
        for (int i = 0; i < 2; i++) begin
            pins.data[8*i+:8] = dataOe[i] ? dataOut[8*i+:8] :
                (hostDrv ? hostData[8*i+:8] : floatPat[8*i+:8]);
        end
    end
    // Bus clock toggles only while a host cycle is under way
    initial begin
        #37;
        forever #100 busClk <= clkEn & ~busClk;
    end
    // Kind: 0 portRd 1 portWr 2 lowRd 3 lowWr 4 memRd 5 memWr
    task automatic hcycle(input int k, input logic [26:0] a, input logic sbheN,
            input logic [15:0] wd, output logic [15:0] rd, output int waits,
            output logic [2:0] seen);
        int i;
        i = 0;
        waits = 0;
        seen = 3'b000;
        rd = 16'h0000;
        @(posedge core_clk);
        drv.addr <= a[19:0];
        drv.upper <= a[26:20];
        drv.sbheN <= sbheN;
        drv.ale <= 1'b1;
        clkEn <= 1'b1;
        repeat (3) @(posedge core_clk);
        drv.ale <= 1'b0;
        repeat (2) @(posedge core_clk);
        drv[20+k] <= 1'b0;
        hostDrv <= k[0];
        hostData <= wd;
        // Strobe held while channel ready is pulled low
        while ((i < 8 || rdyOe) && i < 80) begin
            @(posedge core_clk);
            i++;
            waits += int'(rdyOe);
            seen |= {|dataOe, portAckOe, memAckOe};
            rd = pins.data;
        end
        drv[25:20] <= 6'h3F;
        hostDrv <= 1'b0;
        repeat (6) @(posedge core_clk);
        clkEn <= 1'b0;
    endtask
endmodule

// *** testbench/isb_bus_if_tb_top.sv ***
// Self-checking bench of the expansion bus slave, with an APB register master.
// Assumes the host model drives every bus pin of the slave.
`timescale 1ns/10ps
module isb_bus_if_tb_top;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, mAckOe, pAckOe, rdyOe, irq;
    logic [15:0] dOut, hRd;
    logic [1:0] dOe;
    logic [2:0] hSeen;
    logic [3:0] irqOut;
    int hWaits;
    int n_mismatch = 0;
    int samples_checked = 0;
    isb_pkg::isb_pins_t pins;
    initial begin
        forever #12.5 core_clk = ~core_clk;
    end
    isb_bus_if i_isb_bus_if (.core_clk(core_clk), .reset_n(reset_n), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .latchedAddr(pins.addr),
        .unlatchedUpperAddr(pins.upper), .addrLatchStrobe(pins.ale),
        .highByteEnableN(pins.sbheN), .memWriteStrobeN(pins.memWrN),
        .memReadStrobeN(pins.memRdN), .lowMemWriteStrobeN(pins.lowMemWrN),
        .lowMemReadStrobeN(pins.lowMemRdN), .portWriteStrobeN(pins.portWrN),
        .portReadStrobeN(pins.portRdN), .dmaActive(pins.dma), .widthSelect(pins.width),
        .hostBusClock(pins.busClk), .hostBusReset(pins.busRst), .sysDataBusIn(pins.data),
        .sysDataBusOut(dOut), .sysDataBusOe(dOe), .wideMemAckOut(), .wideMemAckOe(mAckOe),
        .widePortAckOut(), .widePortAckOe(pAckOe), .channelReadyOut(),
        .channelReadyOe(rdyOe), .irqOutputs(irqOut), .irq(irq));
    isb_host_model i_isb_host_model (.core_clk(core_clk), .dataOut(dOut), .dataOe(dOe),
        .rdyOe(rdyOe), .memAckOe(mAckOe), .portAckOe(pAckOe), .pins(pins));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) begin
            @(posedge core_clk);
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, exp, what);
    endtask
    task automatic hc(input int k, input logic [26:0] a, input logic [15:0] wd);
        i_isb_host_model.hcycle(k, a, 1'b0, wd, hRd, hWaits, hSeen);
        chk(32'({pAckOe, rdyOe, dOe}), 32'h0, "pins released");
    endtask
    task automatic t_regs();
        logic [31:0] r;
        logic e;
        rdc(isb_pkg::OFS_CTRL, 32'(isb_pkg::CTRL_RST), "ctrl reset");
        rdc(isb_pkg::OFS_IOBASE, 32'(isb_pkg::IOBASE_RST), "iobase reset");
        apb(1'b0, 8'h28, 32'h0, r, e);
        chk({r[30:0], e}, 32'h1, "unmapped read");
        $display("t_regs done");
    endtask
    task automatic t_port();
        i_isb_host_model.drv.width <= 1'b1;
        wr(isb_pkg::OFS_IOBASE, 32'h0);
        wr(isb_pkg::OFS_CTRL, 32'h21);
        wr(isb_pkg::OFS_MASK, 32'h2);
        wr(isb_pkg::OFS_RDDATA, 32'h1234);
        hc(1, 27'h6, 16'hA55A);
        rdc(isb_pkg::OFS_WRDATA, 32'hA55A, "port write data");
        rdc(isb_pkg::OFS_WRADDR, 32'h6, "captured address");
        chk(32'(irq), 32'h0, "masked event");
        hc(0, 27'h6, 16'h0);
        chk(32'(hRd), 32'h1234, "port read data");
        chk(32'(hSeen), 32'h6, "wide port ack");
        chk(32'(hWaits), 32'h2, "wait states");
        chk(32'(irqOut), 32'h1, "direct irq pin");
        rdc(isb_pkg::OFS_STATUS, 32'h3, "status");
        @(posedge core_clk);
        chk(32'(irq), 32'h0, "irq cleared");
        wr(isb_pkg::OFS_CTRL, 32'h523);
        hc(0, 27'h6, 16'h0);
        chk(32'(irqOut), 32'hD, "coded irq pins");
        rdc(isb_pkg::OFS_STATUS, 32'h2, "status coded");
        i_isb_host_model.drv.dma <= 1'b1;
        hc(0, 27'h6, 16'h0);
        chk(32'(hSeen), 32'h0, "dma cycle answered");
        rdc(isb_pkg::OFS_STATUS, 32'h0, "dma event");
        i_isb_host_model.drv.dma <= 1'b0;
        $display("t_port done");
    endtask
    task automatic t_mem();
        wr(isb_pkg::OFS_CTRL, 32'h20);
        wr(isb_pkg::OFS_MEMBASE, 32'h28C);
        wr(isb_pkg::OFS_RDDATA, 32'hBEEF);
        hc(4, 27'h0C14000, 16'h0);
        chk(32'(hRd), 32'hBEEF, "mem read data");
        chk(32'(hSeen), 32'h5, "wide mem ack");
        hc(4, 27'h0C00000, 16'h0);
        chk(32'(hSeen), 32'h1, "region only");
        rdc(isb_pkg::OFS_STATUS, 32'h8, "mem status");
        i_isb_host_model.drv.width <= 1'b0;
        hc(2, 27'h0C14001, 16'h0);
        chk({hRd[7:0], 21'h0, hSeen}, {8'hBE, 24'h4}, "8-bit odd read");
        rdc(isb_pkg::OFS_STATUS, 32'h8, "low strobe status");
        $display("t_mem done");
    endtask
    task automatic t_rom_clk();
        i_isb_host_model.drv.width <= 1'b1;
        wr(isb_pkg::OFS_CTRL, 32'h25);
        wr(isb_pkg::OFS_ROMBASE, 32'h3);
        hc(2, 27'h000C000, 16'h0);
        rdc(isb_pkg::OFS_STATUS, 32'h10, "rom status");
        hc(0, 27'h6, 16'h0);
        chk(32'(hWaits > 4), 32'h1, "host clock waits");
        chk(32'(hRd), 32'hBEEF, "paced read data");
        hc(1, 27'h6, 16'h0001);
        i_isb_host_model.drv.busRst <= 1'b1;
        repeat (4) @(posedge core_clk);
        i_isb_host_model.drv.busRst <= 1'b0;
        rdc(isb_pkg::OFS_STATUS, 32'h0, "bus reset status");
        rdc(isb_pkg::OFS_CTRL, 32'h25, "config kept");
        $display("t_rom_clk done");
    endtask
    initial begin
        repeat (4) @(posedge core_clk);
        reset_n <= 1'b1;
        t_regs();
        t_port();
        t_mem();
        t_rom_clk();
        stop_test();
    end
    // About 80000 cycles, far beyond the whole sequence
    initial begin
        #2000000;
        n_mismatch++;
        stop_test();
    end
endmodule
